// [tb/gcm_pins_model.sv]
// pin-side model: count source and gate levels driven from outside the channel
`timescale 1ns/100ps
module gcm_pins_model (
  // clock used only to pace the pin changes
  input wire logic pclk,
  // pins toward the channel
  output logic src_in,
  output logic gate_in
);
  initial begin
    src_in = 1'b0;
    gate_in = 1'b0;
  end

  // phases held well past the synchroniser so no edge is merged or lost
  task automatic src_pulses(input int n);
    repeat (n) begin
      @(posedge pclk);
      src_in <= 1'b1;
      repeat (5) @(posedge pclk);
      src_in <= 1'b0;
      repeat (5) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask

  task automatic set_gate(input logic v);
    @(posedge pclk);
    gate_in <= v;
    repeat (8) @(posedge pclk);
  endtask
endmodule

// [tb/testbench.sv]
// self-checking bench for the gated counter channel
`timescale 1ns/100ps
module testbench;
  import gcm_pkg::*;
  typedef struct {logic rd; logic err; logic [31:0] data; logic [31:0] mask; string name;} gcm_note_t;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [3:0] pstrb;
  logic pready;
  logic pslverr;
  logic src_in;
  logic gate_in;
  logic out_o;
  logic out_oe;
  logic tc_flag;
  logic wave;
  int mismatches;
  int total_checks;
  int cycles;
  int seed;
  logic [15:0] p;
  gcm_note_t notes[$];
  gcm_note_t n;

  gcm_counter gcm_counter_inst (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .src_in(src_in),
    .gate_in(gate_in),
    .out_o(out_o),
    .out_oe(out_oe),
    .terminal_count_flag(tc_flag),
    .halved_terminal_count_wave(wave)
  );

  gcm_pins_model gcm_pins_model_inst (
    .pclk(pclk),
    .src_in(src_in),
    .gate_in(gate_in)
  );

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  function automatic void chk(input string nm, input logic [32:0] e, input logic [32:0] s);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // the master notes what it expects and only flags a missing pready; the watcher below judges the answer
  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d, input logic err,
                     input logic [31:0] e, input logic [31:0] m, input string nm);
    int w;
    notes.push_back('{~wr, err, e, m, nm});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'($random(seed)), d[15:0]};
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (w >= 50) begin
      mismatches++;
      $display("CHECK FAILED pready expected 1 seen 0");
      final_report();
    end
  endtask

  task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 32'h0000_0000, 32'h0000_0000, "write");
  endtask

  task automatic rd(input logic [APB_AW-1:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0000_0000, 1'b0, e, 32'hFFFF_FFFF, nm);
  endtask

  // registered pins need a few cycles after the causing write or edge
  task automatic pin(input string nm, input logic eo, input logic eoe);
    repeat (3) @(posedge pclk);
    chk({nm, " out_o"}, {32'h0, eo}, {32'h0, out_o});
    chk({nm, " out_oe"}, {32'h0, eoe}, {32'h0, out_oe});
  endtask

  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (notes.size() == 0) begin
        mismatches++;
        $display("CHECK FAILED answer expected none seen %h", prdata);
      end else begin
        n = notes.pop_front();
        chk(n.name, {n.err, n.data & n.mask}, {pslverr, (n.rd ? prdata : 32'h0000_0000) & n.mask});
      end
    end
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      $display("CHECK FAILED run length expected below 8000 seen 8000");
      final_report();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'h3;
    mismatches = 0;
    total_checks = 0;
    cycles = 0;
    seed = 40;
    p = 16'h0003 + 16'($random(seed) & 3);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    // reset values, refused accesses
    rd(OFS_SETUP, 32'h0000_0800, "setup");
    rd(OFS_PRESET, 32'h0000_0000, "preset");
    apb(1'b0, 8'h20, 32'h0000_0000, 1'b1, 32'h0000_0000, 32'hFFFF_FFFF, "unmapped");
    apb(1'b1, OFS_COUNT, 32'h0000_1234, 1'b1, 32'h0000_0000, 32'h0000_0000, "ro write");
    apb(1'b1, 8'hC3, 32'h0000_0001, 1'b1, 32'h0000_0000, 32'h0000_0000, "unmapped write");
    // byte lanes: only the upper lane, then only lanes above the register
    pstrb <= 4'h2;
    wr(OFS_PRESET, 32'h0000_5A5A);
    pstrb <= 4'hC;
    wr(OFS_PRESET, 32'h0000_FFFF);
    pstrb <= 4'h3;
    rd(OFS_PRESET, 32'h0000_5A00, "byte lanes");
    rd(OFS_COUNT, 32'h0000_0000, "count");
    chk("out_oe", 33'h1, {32'h0, out_oe});
    chk("out_o", 33'h0, {32'h0, out_o});
    $display("test reset done");
    // free run with toggled output, no gating
    wr(OFS_SETUP, 32'h0000_0822);
    wr(OFS_PRESET, {16'h0000, p});
    wr(OFS_CMD, 32'h0000_0015);
    rd(OFS_COUNT, {16'h0000, p}, "count load");
    gcm_pins_model_inst.src_pulses(int'(p) - 1);
    rd(OFS_COUNT, 32'h0000_0001, "count one");
    gcm_pins_model_inst.src_pulses(1);
    rd(OFS_COUNT, {16'h0000, p}, "count reload");
    apb(1'b0, OFS_STATUS, 32'h0, 1'b0, 32'h0000_0009, 32'h0000_0019, "status tc");
    chk("tc flag", 33'h1, {32'h0, tc_flag});
    gcm_pins_model_inst.src_pulses(1);
    rd(OFS_COUNT, {16'h0000, p - 16'h0001}, "count after tc");
    apb(1'b0, OFS_STATUS, 32'h0, 1'b0, 32'h0000_0011, 32'h0000_0019, "status toggle");
    chk("out toggled", 33'h1, {32'h0, out_o});
    chk("wave", 33'h1, {32'h0, wave});
    wr(OFS_CMD, 32'h0000_0010);
    pin("force low", 1'b0, 1'b1);
    chk("force low", 33'h0, {32'h0, out_o});
    wr(OFS_CMD, 32'h0000_0008);
    pin("force high", 1'b1, 1'b1);
    chk("force high", 33'h1, {32'h0, out_o});
    $display("test free run done");
    // synchronised rate generator with level gating
    wr(OFS_CMD, 32'h0000_0002);
    wr(OFS_SETUP, 32'h0000_88A0);
    wr(OFS_CMD, 32'h0000_0005);
    gcm_pins_model_inst.src_pulses(2);
    rd(OFS_COUNT, {16'h0000, p}, "gated off");
    gcm_pins_model_inst.set_gate(1'b1);
    rd(OFS_CAPTURE, {16'h0000, p}, "capture");
    gcm_pins_model_inst.src_pulses(3);
    rd(OFS_COUNT, {16'h0000, p - 16'h0002}, "gated count");
    gcm_pins_model_inst.set_gate(1'b0);
    gcm_pins_model_inst.set_gate(1'b1);
    rd(OFS_CAPTURE, {16'h0000, p - 16'h0002}, "retrig capture");
    gcm_pins_model_inst.src_pulses(1);
    rd(OFS_COUNT, {16'h0000, p}, "retrig load");
    chk("out low", 33'h0, {32'h0, out_o});
    $display("test rate generator done");
    // retriggerable one-shot with edge gating
    wr(OFS_CMD, 32'h0000_0002);
    gcm_pins_model_inst.set_gate(1'b0);
    wr(OFS_SETUP, 32'h0000_C0A0);
    gcm_pins_model_inst.set_gate(1'b1);
    rd(OFS_CAPTURE, {16'h0000, p - 16'h0002}, "disarmed edge");
    gcm_pins_model_inst.set_gate(1'b0);
    wr(OFS_CMD, 32'h0000_0001);
    gcm_pins_model_inst.set_gate(1'b1);
    rd(OFS_CAPTURE, {16'h0000, p}, "trigger capture");
    gcm_pins_model_inst.set_gate(1'b0);
    gcm_pins_model_inst.src_pulses(3);
    rd(OFS_COUNT, {16'h0000, p - 16'h0002}, "oneshot count");
    gcm_pins_model_inst.src_pulses(int'(p));
    rd(OFS_COUNT, {16'h0000, p - 16'h0001}, "oneshot halt");
    $display("test one-shot done");
    // pin disabled, then global init
    wr(OFS_CMD, 32'h0000_0002);
    wr(OFS_SETUP, 32'h0000_0804);
    pin("hiz", 1'b0, 1'b0);
    chk("hiz", 33'h0, {32'h0, out_oe});
    wr(OFS_CMD, 32'h0000_0020);
    rd(OFS_SETUP, 32'h0000_0800, "init setup");
    pin("init", 1'b0, 1'b1);
    chk("init oe", 33'h1, {32'h0, out_oe});
    $display("test init done");
    // hardware save with toggled output; minimum delay shows on the second source pulse
    wr(OFS_PRESET, 32'h0000_0001);
    wr(OFS_SETUP, 32'h0000_C002);
    wr(OFS_CMD, 32'h0000_0015);
    gcm_pins_model_inst.src_pulses(2);
    rd(OFS_COUNT, 32'h0000_0001, "save idle");
    gcm_pins_model_inst.set_gate(1'b1);
    apb(1'b0, OFS_STATUS, 32'h0, 1'b0, 32'h0000_0003, 32'h0000_0003, "save start");
    gcm_pins_model_inst.src_pulses(1);
    rd(OFS_COUNT, 32'h0000_0001, "save tc reload");
    chk("wave first pulse", 33'h0, {32'h0, wave});
    gcm_pins_model_inst.src_pulses(1);
    pin("wave second pulse", 1'b1, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0, 1'b0, 32'h0000_0001, 32'h0000_0003, "save halt");
    wr(OFS_PRESET, 32'h0000_0005);
    wr(OFS_CMD, 32'h0000_0004);
    gcm_pins_model_inst.set_gate(1'b0);
    gcm_pins_model_inst.set_gate(1'b1);
    gcm_pins_model_inst.src_pulses(2);
    gcm_pins_model_inst.set_gate(1'b0);
    gcm_pins_model_inst.set_gate(1'b1);
    rd(OFS_CAPTURE, 32'h0000_0003, "save capture");
    gcm_pins_model_inst.src_pulses(1);
    rd(OFS_COUNT, 32'h0000_0002, "save undisturbed");
    gcm_pins_model_inst.src_pulses(4);
    rd(OFS_COUNT, 32'h0000_0004, "save halted");
    $display("test hardware save done");
    // bcd up count on falling source edges, active-low terminal count pin
    wr(OFS_CMD, 32'h0000_0002);
    wr(OFS_SETUP, 32'h0000_103D);
    wr(OFS_PRESET, 32'h0000_0999);
    wr(OFS_CMD, 32'h0000_0005);
    gcm_pins_model_inst.src_pulses(1);
    rd(OFS_COUNT, 32'h0000_1000, "bcd carry");
    wr(OFS_PRESET, 32'h0000_9999);
    wr(OFS_CMD, 32'h0000_0004);
    gcm_pins_model_inst.src_pulses(1);
    rd(OFS_COUNT, 32'h0000_9999, "bcd reload");
    pin("tc low", 1'b0, 1'b1);
    gcm_pins_model_inst.src_pulses(1);
    rd(OFS_COUNT, 32'h0000_0000, "bcd wrap");
    pin("tc low end", 1'b1, 1'b1);
    $display("test bcd done");
    final_report();
  end
endmodule

// [verilog/gcm_counter.sv]
// gated 16-bit counter channel with apb registers
`timescale 1ns/100ps
module gcm_counter (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gcm_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // counter pins
  input wire logic src_in,
  input wire logic gate_in,
  output logic out_o,
  output logic out_oe,
  // state for neighbours
  output logic terminal_count_flag,
  output logic halved_terminal_count_wave
);
  import gcm_pkg::*;

  logic [15:0] setup_r, preset_r, capture_r, count_r;
  logic armed_r, running_r, pend_r, tc_r, toggle_r;
  logic [2:0] src_s_r, gate_s_r;
  logic src_f_r, src_d_r, gate_f_r, gate_lvl_d_r;
  logic pready_r, pslverr_r, out_r, out_oe_r;
  logic [31:0] prdata_r, rd_data;
  logic rd_ok, wr_ok;

  function automatic logic [15:0] step_val(input logic [15:0] v, input logic up, input logic bcd);
    logic [15:0] r;
    logic [3:0] d;
    logic cy;
    r = v;
    cy = 1'b1;
    if (!bcd) begin
      r = up ? v + 16'h0001 : v - 16'h0001;
    end else begin
      for (int i = 0; i < 4; i++) begin
        d = v[i*4 +: 4];
        if (cy && up) begin
          cy = (d == 4'h9);
          d = cy ? 4'h0 : d + 4'h1;
        end else if (cy) begin
          cy = (d == 4'h0);
          d = cy ? 4'h9 : d - 4'h1;
        end
        r[i*4 +: 4] = d;
      end
    end
    return r;
  endfunction

  function automatic logic is_term(input logic [15:0] v, input logic up, input logic bcd);
    if (!up) begin
      return v == TERM_DOWN;
    end
    return bcd ? (v == TERM_BCD) : (v == TERM_BIN);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // apb decode; a write lands at the edge that samples pready high
  logic acc, wr, setup_wr, preset_wr, cmd_wr;
  assign acc = psel && penable && pready_r;
  assign wr = acc && pwrite;
  assign setup_wr = wr && (paddr == OFS_SETUP);
  assign preset_wr = wr && (paddr == OFS_PRESET);
  assign cmd_wr = wr && (paddr == OFS_CMD) && pstrb[0];

  logic cmd_arm, cmd_disarm, cmd_load, cmd_set, cmd_clr, cmd_init, cmd_any;
  assign cmd_arm = cmd_wr && pwdata[C_ARM];
  assign cmd_disarm = cmd_wr && pwdata[C_DISARM];
  assign cmd_load = cmd_wr && pwdata[C_LOAD];
  assign cmd_set = cmd_wr && pwdata[C_SET];
  assign cmd_clr = cmd_wr && pwdata[C_CLR];
  assign cmd_init = cmd_wr && pwdata[C_INIT];
  assign cmd_any = cmd_wr;

  // mode decode
  logic [2:0] gate_code, ctl;
  logic gate_none, edge_mode, level_mode, sync_rate, one_shot, hw_save, retrig_en, gate_low;
  logic up, bcd;
  assign gate_code = setup_r[F_GATE_LSB +: 3];
  assign ctl = setup_r[F_CTL_LSB +: 3];
  assign up = setup_r[F_UP];
  assign bcd = setup_r[F_BCD];
  assign gate_none = (gate_code == GATE_NONE);
  assign edge_mode = (gate_code == GATE_EDGE_HI) || (gate_code == GATE_EDGE_LO);
  assign level_mode = !gate_none && !edge_mode;
  assign sync_rate = level_mode && (ctl == CTL_RETRIG_RPT);
  assign one_shot = edge_mode && (ctl == CTL_RETRIG_RPT);
  assign hw_save = edge_mode && (ctl == CTL_SAVE);
  assign retrig_en = !gate_none && setup_r[F_RETRIG];
  assign gate_low = (gate_code == GATE_LVL_LO) || (gate_code == GATE_EDGE_LO);

  // pin sampling: three stages, a level counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_s_r <= 3'h0;
      gate_s_r <= 3'h0;
      src_f_r <= 1'b0;
      src_d_r <= 1'b0;
      gate_f_r <= 1'b0;
    end else begin
      src_s_r <= {src_s_r[1:0], src_in};
      gate_s_r <= {gate_s_r[1:0], gate_in};
      if (src_s_r[1] == src_s_r[2]) begin
        src_f_r <= src_s_r[2];
      end
      if (gate_s_r[1] == gate_s_r[2]) begin
        gate_f_r <= gate_s_r[2];
      end
      src_d_r <= src_f_r;
    end
  end

  logic gate_lvl, gate_edge, src_edge, count_ok, cnt_ev, tc_trail, capture_ev;
  assign gate_lvl = gate_f_r ^ gate_low;
  assign gate_edge = gate_lvl && !gate_lvl_d_r;
  assign src_edge = (src_f_r != src_d_r) && (src_f_r == !setup_r[F_POL]);
  // level modes need the gate, edge modes a trigger, no gating only arm
  assign count_ok = gate_none ? armed_r : (edge_mode ? armed_r && running_r : armed_r && gate_lvl);
  assign cnt_ev = src_edge && count_ok;
  // trailing edge of terminal count is counted even when gated off or disarmed
  assign tc_trail = src_edge && tc_r;
  assign capture_ev = gate_edge && armed_r && (retrig_en || (hw_save && running_r));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_lvl_d_r <= 1'b0;
    end else begin
      gate_lvl_d_r <= gate_lvl;
    end
  end

  // setup register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_r <= SETUP_RST;
    end else if (cmd_init) begin
      setup_r <= SETUP_RST;
    end else if (setup_wr) begin
      setup_r <= merge16(setup_r, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preset_r <= PRESET_RST;
    end else if (preset_wr) begin
      preset_r <= merge16(preset_r, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_r <= CTR_RST;
    end else if (capture_ev) begin
      capture_r <= count_r;
    end
  end

  // counting core; commands come last so they win over hardware events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= CTR_RST;
      armed_r <= 1'b0;
      running_r <= 1'b0;
      pend_r <= 1'b0;
      tc_r <= 1'b0;
    end else begin
      if (tc_trail) begin
        tc_r <= 1'b0;
        count_r <= step_val(count_r, up, bcd);
      end else if (cnt_ev) begin
        if (pend_r) begin
          count_r <= preset_r;
          pend_r <= 1'b0;
        end else if (is_term(count_r, up, bcd)) begin
          count_r <= preset_r;
          tc_r <= 1'b1;
          if (edge_mode) begin
            running_r <= 1'b0;
          end else if (!setup_r[F_CTL_LSB]) begin
            armed_r <= 1'b0;
          end
        end else begin
          count_r <= step_val(count_r, up, bcd);
        end
      end
      // disarmed counters never see the gate edge
      if (gate_edge && armed_r && !gate_none) begin
        if (edge_mode) begin
          running_r <= 1'b1;
        end
        if (retrig_en) begin
          pend_r <= 1'b1;
        end
      end
      if (cmd_arm) begin
        armed_r <= 1'b1;
      end
      if (cmd_load) begin
        count_r <= preset_r;
        pend_r <= 1'b0;
      end
      if (cmd_disarm || cmd_init) begin
        armed_r <= 1'b0;
        running_r <= 1'b0;
        pend_r <= 1'b0;
      end
      if (cmd_init) begin
        tc_r <= 1'b0;
      end
    end
  end

  // toggled wave flips when terminal count ends, set and clear commands force it, holds otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      toggle_r <= 1'b0;
    end else if (cmd_set) begin
      toggle_r <= 1'b1;
    end else if (cmd_clr) begin
      toggle_r <= 1'b0;
    end else if (tc_trail) begin
      toggle_r <= !toggle_r;
    end
  end

  // output pin, registered so the pin never glitches on decode changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= 1'b0;
      out_oe_r <= 1'b1;
    end else begin
      unique case (setup_r[F_PIN_LSB +: 3])
        PIN_LOW: begin
          out_r <= 1'b0;
          out_oe_r <= 1'b1;
        end
        PIN_TC_HI: begin
          out_r <= tc_r;
          out_oe_r <= 1'b1;
        end
        PIN_TC_LO: begin
          out_r <= !tc_r;
          out_oe_r <= 1'b1;
        end
        PIN_TOGGLE: begin
          out_r <= toggle_r;
          out_oe_r <= 1'b1;
        end
        default: begin
          out_r <= 1'b0;
          out_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // apb read mux
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    wr_ok = 1'b1;
    unique case (paddr)
      OFS_SETUP: rd_data[15:0] = setup_r;
      OFS_PRESET: rd_data[15:0] = preset_r;
      OFS_CAPTURE: begin
        rd_data[15:0] = capture_r;
        wr_ok = 1'b0;
      end
      OFS_COUNT: begin
        rd_data[15:0] = count_r;
        wr_ok = 1'b0;
      end
      OFS_CMD: rd_data = 32'h0000_0000;
      OFS_STATUS: begin
        rd_data[4:0] = {toggle_r, tc_r, pend_r, running_r, armed_r};
        wr_ok = 1'b0;
      end
      default: begin
        rd_ok = 1'b0;
        wr_ok = 1'b0;
      end
    endcase
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (psel && penable && !pready_r) begin
      pready_r <= 1'b1;
      pslverr_r <= pwrite ? !wr_ok : !rd_ok;
      prdata_r <= (pwrite || !rd_ok) ? 32'h0000_0000 : rd_data;
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign out_o = out_r;
  assign out_oe = out_oe_r;
  assign terminal_count_flag = tc_r;
  assign halved_terminal_count_wave = toggle_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_init_setup: assert property (cmd_init |=> setup_r == SETUP_RST)
    else $error("init command did not restore setup");
  a_tc_one_period: assert property (tc_trail && !cmd_init |=> !tc_r)
    else $error("terminal count outlived its source period");
  a_tc_reload: assert property ($rose(tc_r) && !$past(cmd_any) && !$past(preset_wr)
      |-> count_r == preset_r)
    else $error("terminal count did not reload preset");
  a_gate_capture: assert property (capture_ev |=> capture_r == $past(count_r))
    else $error("gate edge did not capture count");
  a_pend_load: assert property (pend_r && cnt_ev && !tc_r && !cmd_any && !gate_edge
      |=> count_r == $past(preset_r) && !pend_r)
    else $error("retrigger did not load preset");
  a_level_block: assert property (sync_rate && src_edge && !gate_lvl && !tc_r && !cmd_any
      |=> $stable(count_r))
    else $error("count moved with gate inactive");
  a_disarm_ignore: assert property (gate_edge && !armed_r && !running_r && !cmd_any
      |=> !running_r && !$rose(pend_r))
    else $error("disarmed counter took a gate edge");
  a_toggle_flip: assert property (tc_trail && !cmd_set && !cmd_clr
      |=> toggle_r != $past(toggle_r))
    else $error("toggle did not flip");
  a_toggle_hold: assert property (!tc_trail && !cmd_set && !cmd_clr |=> $stable(toggle_r))
    else $error("toggle changed without terminal count");
  a_oneshot_halt: assert property (one_shot && $rose(tc_r) && !$past(gate_edge) |-> !running_r)
    else $error("one-shot did not halt at terminal count");
  a_pin_low: assert property (setup_r[2:0] == PIN_LOW ##1 setup_r[2:0] == PIN_LOW
      |-> out_oe && !out_o)
    else $error("output not held low");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");

  c_sync_tc: cover property (sync_rate && $rose(tc_r));
  c_oneshot_retrig: cover property (one_shot && capture_ev ##[1:50] pend_r && cnt_ev);
  c_save_capture: cover property (hw_save && running_r && capture_ev);
  c_toggle: cover property (tc_trail && setup_r[2:0] == PIN_TOGGLE);
endmodule

// [verilog/gcm_pkg.sv]
// constants shared by the gated counter channel
package gcm_pkg;
  localparam int unsigned APB_AW = 8;
  // register byte offsets
  localparam logic [7:0] OFS_SETUP = 8'h00;
  localparam logic [7:0] OFS_PRESET = 8'h04;
  localparam logic [7:0] OFS_CAPTURE = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // values after reset
  localparam logic [15:0] SETUP_RST = 16'h0800;
  localparam logic [15:0] PRESET_RST = 16'h0000;
  localparam logic [15:0] CTR_RST = 16'h0000;
  // operating_setup_reg field positions
  localparam int unsigned F_PIN_LSB = 0;
  localparam int unsigned F_BCD = 3;
  localparam int unsigned F_UP = 4;
  localparam int unsigned F_CTL_LSB = 5;
  localparam int unsigned F_RETRIG = 7;
  localparam int unsigned F_POL = 12;
  localparam int unsigned F_GATE_LSB = 13;
  // gating field codes
  localparam logic [2:0] GATE_NONE = 3'h0;
  localparam logic [2:0] GATE_LVL_LO = 3'h5;
  localparam logic [2:0] GATE_EDGE_HI = 3'h6;
  localparam logic [2:0] GATE_EDGE_LO = 3'h7;
  // bits 7..5 patterns
  localparam logic [2:0] CTL_RETRIG_RPT = 3'h5;
  localparam logic [2:0] CTL_SAVE = 3'h0;
  // pin_behaviour_field codes
  localparam logic [2:0] PIN_LOW = 3'h0;
  localparam logic [2:0] PIN_TC_HI = 3'h1;
  localparam logic [2:0] PIN_TOGGLE = 3'h2;
  localparam logic [2:0] PIN_HIZ = 3'h4;
  localparam logic [2:0] PIN_TC_LO = 3'h5;
  // command register bit positions
  localparam int unsigned C_ARM = 0;
  localparam int unsigned C_DISARM = 1;
  localparam int unsigned C_LOAD = 2;
  localparam int unsigned C_SET = 3;
  localparam int unsigned C_CLR = 4;
  localparam int unsigned C_INIT = 5;
  // terminal values one count before terminal count
  localparam logic [15:0] TERM_DOWN = 16'h0001;
  localparam logic [15:0] TERM_BCD = 16'h9999;
  localparam logic [15:0] TERM_BIN = 16'hFFFF;
endpackage
